// ### verilog/tw_pkg.sv
// Shared constants and types for the two-wire memory link
package tw_pkg;
  // Clock and timing
  localparam int CLK_MHZ = 50;
  localparam int CLK_NS = 20;
  localparam int SPIKE_NS = 50;
  localparam int FILT_CYC = SPIKE_NS / CLK_NS;
  localparam int FILT_HOLD = FILT_CYC + 2;
  localparam int PROG_TIME_US = 5000;
  localparam int PROG_CYC = PROG_TIME_US * CLK_MHZ;
  localparam int QTR_NS = 625;
  localparam int QTR_CYC = (QTR_NS + CLK_NS - 1) / CLK_NS;
  localparam int RECOVER_MAX = 9;
  // Memory shape
  localparam int ADDR_W = 13;
  localparam int PAGE_W = 5;
  localparam int PAGE_BYTES = 32;
  localparam int MEM_BYTES = 8192;
  // Device type code, arbitrary value
  localparam logic [3:0] DEV_TYPE = 4'h5;
  // Controller register byte offsets
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_TX = 8'h04;
  localparam logic [7:0] REG_RX = 8'h08;
  // Command and status fields
  localparam int CMD_ACK_BIT = 3;
  localparam int STAT_BUSY = 0;
  localparam int STAT_ACK = 1;
  localparam int STAT_LINE = 2;
  // Reset values
  localparam logic [7:0] TX_RST = 8'h00;
  localparam logic [7:0] RX_RST = 8'h00;
  // Controller operations
  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_START = 3'h1,
    OP_STOP = 3'h2,
    OP_WRITE = 3'h3,
    OP_READ = 3'h4,
    OP_RECOVER = 3'h5
  } tw_op_t;
  // Target states
  typedef enum logic [2:0] {
    DS_IDLE = 3'h0,
    DS_RX = 3'h1,
    DS_ACK = 3'h2,
    DS_TX = 3'h3,
    DS_RACK = 3'h4,
    DS_RLOAD = 3'h5,
    DS_PROG = 3'h6
  } tw_dst_t;
endpackage

// ### verilog/tw_bus_if.sv
// Open-drain two-wire bus joining controller and target
`timescale 1ns/1ns
`default_nettype none
interface tw_bus_if;
  logic ctl_scl_out;
  logic ctl_scl_oe;
  logic ctl_sda_out;
  logic ctl_sda_oe;
  logic dev_sda_out;
  logic dev_sda_oe;
  logic scl;
  logic sda;
  // Wired-and with pull-up
  assign scl = !(ctl_scl_oe && !ctl_scl_out);
  assign sda = !((ctl_sda_oe && !ctl_sda_out) || (dev_sda_oe && !dev_sda_out));
  modport dev (input scl, input sda, output dev_sda_out, output dev_sda_oe);
  modport ctl (input scl, input sda, output ctl_scl_out, output ctl_scl_oe,
               output ctl_sda_out, output ctl_sda_oe);
endinterface
`default_nettype wire

// ### verilog/tw_filt.sv
// Pin synchroniser with spike filter
`timescale 1ns/1ns
`default_nettype none
module tw_filt
  import tw_pkg::*;
(
  // Clock, reset, enable
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // Raw pin and clean level
  input wire logic pin_in,
  output logic level_out
);
  logic s1_q;
  logic s2_q;
  logic [3:0] cnt_q;

  // Two-flop synchroniser, idle high
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
    end else if (ce_in) begin
      s1_q <= pin_in;
      s2_q <= s1_q;
    end
  end

  // Accept a new level only after it persists past a spike
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      level_out <= 1'b1;
      cnt_q <= 4'h0;
    end else if (ce_in) begin
      if (s2_q == level_out) begin
        cnt_q <= 4'h0;
      end else if (cnt_q == 4'(FILT_HOLD - 1)) begin
        level_out <= s2_q;
        cnt_q <= 4'h0;
      end else begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ### verilog/tw_dev.sv
// Two-wire serial memory target: framing, addressing, page write, program cycle
//
// Local design decisions: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module tw_dev
  import tw_pkg::*;
#(
  parameter int PROG_CYC_P = PROG_CYC
) (
  // Clock, reset, enable
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // Two-wire bus
  tw_bus_if.dev bus,
  // Straps and write protect pins
  input wire logic strap_sel_bit2_in,
  input wire logic strap_sel_bit1_in,
  input wire logic strap_sel_bit0_in,
  input wire logic write_protect_in,
  // Status
  output logic standby_out,
  output logic busy_out
);
  tw_dst_t state_q;
  logic [3:0] pin_s1_q;
  logic [3:0] pin_s2_q;
  logic scl_l;
  logic sda_l;
  logic scl_p_q;
  logic sda_p_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] sh_q;
  logic [7:0] tx_q;
  logic [1:0] byte_idx_q;
  logic rw_q;
  logic drive_q;
  logic wr_pend_q;
  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-PAGE_W-1:0] page_q;
  logic [PAGE_BYTES-1:0] mask_q;
  logic [23:0] prog_cnt_q;
  logic [7:0] mem [MEM_BYTES];
  logic [7:0] pbuf [PAGE_BYTES];

  // Address word check against type and straps
  function automatic logic dev_match(input logic [7:0] b, input logic [2:0] st);
    dev_match = (b[7:4] == DEV_TYPE) && (b[3:1] == st);
  endfunction

  // Straps and protect pin, pads pull low when floating
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      pin_s1_q <= 4'h0;
      pin_s2_q <= 4'h0;
    end else if (ce_in) begin
      pin_s1_q <= {write_protect_in, strap_sel_bit2_in, strap_sel_bit1_in, strap_sel_bit0_in};
      pin_s2_q <= pin_s1_q;
    end
  end

  // Filtered bus inputs
  tw_filt u_scl_filt (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .pin_in(bus.scl),
    .level_out(scl_l)
  );
  tw_filt u_sda_filt (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .pin_in(bus.sda),
    .level_out(sda_l)
  );

  // Previous levels for edge detection
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else if (ce_in) begin
      scl_p_q <= scl_l;
      sda_p_q <= sda_l;
    end
  end

  // Bus events and decodes
  wire logic [2:0] straps = pin_s2_q[2:0];
  wire logic wp_s = pin_s2_q[3];
  wire logic scl_rise = scl_l && !scl_p_q;
  wire logic scl_fall = !scl_l && scl_p_q;
  wire logic start_ev = scl_l && scl_p_q && sda_p_q && !sda_l;
  wire logic stop_ev = scl_l && scl_p_q && !sda_p_q && sda_l;
  wire logic byte_done = (state_q == DS_RX) && scl_fall && (bit_cnt_q == 4'h8);
  wire logic data_we = byte_done && (byte_idx_q == 2'h3);
  wire logic [PAGE_W-1:0] prog_idx = prog_cnt_q[PAGE_W-1:0];
  wire logic [7:0] rd_byte = mem[addr_q];

  // Page buffer fill at the current in-page offset
  always_ff @(posedge ref_clk_in) begin
    if (ce_in && data_we) begin
      pbuf[addr_q[PAGE_W-1:0]] <= sh_q;
    end
  end

  // Array commit, one buffered byte per cycle while programming
  always_ff @(posedge ref_clk_in) begin
    if (ce_in && (state_q == DS_PROG) && mask_q[prog_idx]) begin
      mem[{page_q, prog_idx}] <= pbuf[prog_idx];
    end
  end

  // Protocol state machine
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      state_q <= DS_IDLE;
      bit_cnt_q <= 4'h0;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      byte_idx_q <= 2'h0;
      rw_q <= 1'b0;
      drive_q <= 1'b0;
      wr_pend_q <= 1'b0;
      addr_q <= '0;
      page_q <= '0;
      mask_q <= '0;
      prog_cnt_q <= 24'h000000;
    end else if (ce_in) begin
      if (state_q == DS_PROG) begin
        // Deaf until programming ends, so polls get no ack
        if (prog_cnt_q == 24'h000000) begin
          state_q <= DS_IDLE;
        end else begin
          prog_cnt_q <= prog_cnt_q - 24'h000001;
        end
      end else if (start_ev) begin
        state_q <= DS_RX;
        bit_cnt_q <= 4'h0;
        byte_idx_q <= 2'h0;
        drive_q <= 1'b0;
        mask_q <= '0;
        wr_pend_q <= 1'b0;
      end else if (stop_ev) begin
        drive_q <= 1'b0;
        if (wr_pend_q && !wp_s) begin
          state_q <= DS_PROG;
          prog_cnt_q <= 24'(PROG_CYC_P - 1);
          page_q <= addr_q[ADDR_W-1:PAGE_W];
        end else begin
          state_q <= DS_IDLE;
        end
      end else begin
        unique case (state_q)
          DS_IDLE: begin
            drive_q <= 1'b0;
          end
          DS_RX: begin
            if (scl_rise && (bit_cnt_q != 4'h8)) begin
              sh_q <= {sh_q[6:0], sda_l};
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end else if (byte_done) begin
              bit_cnt_q <= 4'h0;
              if ((byte_idx_q == 2'h0) && !dev_match(sh_q, straps)) begin
                state_q <= DS_IDLE;
              end else begin
                state_q <= DS_ACK;
                drive_q <= 1'b1;
              end
              unique case (byte_idx_q)
                2'h0: rw_q <= sh_q[0];
                2'h1: addr_q[ADDR_W-1:8] <= sh_q[ADDR_W-9:0];
                2'h2: addr_q[7:0] <= sh_q;
                2'h3: begin
                  mask_q[addr_q[PAGE_W-1:0]] <= 1'b1;
                  addr_q[PAGE_W-1:0] <= addr_q[PAGE_W-1:0] + 5'h01;
                  wr_pend_q <= 1'b1;
                end
              endcase
            end
          end
          DS_ACK: begin
            if (scl_fall) begin
              if (rw_q) begin
                state_q <= DS_TX;
                tx_q <= rd_byte;
                drive_q <= !rd_byte[7];
                bit_cnt_q <= 4'h1;
              end else begin
                state_q <= DS_RX;
                drive_q <= 1'b0;
                if (byte_idx_q != 2'h3) begin
                  byte_idx_q <= byte_idx_q + 2'h1;
                end
              end
            end
          end
          DS_TX: begin
            if (scl_fall) begin
              if (bit_cnt_q == 4'h8) begin
                state_q <= DS_RACK;
                drive_q <= 1'b0;
              end else begin
                tx_q <= {tx_q[6:0], 1'b0};
                drive_q <= !tx_q[6];
                bit_cnt_q <= bit_cnt_q + 4'h1;
              end
            end
          end
          DS_RACK: begin
            if (scl_rise) begin
              if (sda_l) begin
                state_q <= DS_IDLE;
              end else begin
                state_q <= DS_RLOAD;
                addr_q <= addr_q + 13'h0001;
              end
            end
          end
          DS_RLOAD: begin
            if (scl_fall) begin
              state_q <= DS_TX;
              tx_q <= rd_byte;
              drive_q <= !rd_byte[7];
              bit_cnt_q <= 4'h1;
            end
          end
          default: begin
            state_q <= DS_IDLE;
          end
        endcase
      end
    end
  end

  // Open-drain data drive and status
  assign bus.dev_sda_out = 1'b0;
  assign bus.dev_sda_oe = drive_q;
  assign standby_out = (state_q == DS_IDLE);
  assign busy_out = (state_q == DS_PROG);
endmodule
`default_nettype wire

// ### verilog/tw_ctl.sv
// Two-wire bus controller with a classic Wishbone register slave
`timescale 1ns/1ns
`default_nettype none
module tw_ctl
  import tw_pkg::*;
(
  // Clock, reset, enable
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // Wishbone slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  // Two-wire bus
  tw_bus_if.ctl bus
);
  tw_op_t op_q;
  logic [5:0] qcnt_q;
  logic [1:0] ph_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q;
  logic [7:0] tx_q;
  logic [7:0] rx_q;
  logic ackbit_q;
  logic ack_rx_q;
  logic rec_hi_q;
  logic scl_lo_q;
  logic sda_lo_q;
  logic scl_l;
  logic sda_l;

  // Filtered bus inputs
  tw_filt u_scl_filt (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .pin_in(bus.scl),
    .level_out(scl_l)
  );
  tw_filt u_sda_filt (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .pin_in(bus.sda),
    .level_out(sda_l)
  );

  // Register decode and read mux
  wire logic req = wb_cyc_in && wb_stb_in;
  wire logic hit_cmd = (wb_adr_in == REG_CMD);
  wire logic hit_tx = (wb_adr_in == REG_TX);
  wire logic hit_rx = (wb_adr_in == REG_RX);
  wire logic wr_go = req && wb_we_in && wb_ack_out && wb_sel_in[0];
  wire logic busy = (op_q != OP_NONE);
  wire logic cmd_ok = (wb_dat_in[2:0] != 3'h0) && (wb_dat_in[2:0] <= 3'h5);
  wire logic [31:0] rd_mux = hit_cmd ? {29'h0, rec_hi_q, ack_rx_q, busy} :
                             hit_tx ? {24'h0, tx_q} :
                             hit_rx ? {24'h0, rx_q} : 32'h0;

  // Line levels for the current quarter of a step
  wire logic tick = (qcnt_q == 6'(QTR_CYC - 1));
  wire logic last_bit = (bit_q == 4'h8);
  wire logic bit_v = (op_q == OP_WRITE) ? (last_bit ? 1'b1 : sh_q[7]) :
                     (op_q == OP_READ) ? (last_bit ? !ackbit_q : 1'b1) : 1'b1;
  wire logic sda_v = (op_q == OP_START) ? !ph_q[1] :
                     (op_q == OP_STOP) ? ph_q[1] : bit_v;
  wire logic scl_v = (op_q == OP_STOP) ? (ph_q != 2'h0) :
                     ((ph_q == 2'h1) || (ph_q == 2'h2));

  // Bus slave answer, one cycle after the request
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0;
    end else if (ce_in) begin
      wb_ack_out <= req && !wb_ack_out;
      if (req && !wb_ack_out) begin
        wb_dat_out <= rd_mux;
      end
    end
  end

  // Command engine, four quarters per bit
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      op_q <= OP_NONE;
      qcnt_q <= 6'h00;
      ph_q <= 2'h0;
      bit_q <= 4'h0;
      sh_q <= TX_RST;
      tx_q <= TX_RST;
      rx_q <= RX_RST;
      ackbit_q <= 1'b0;
      ack_rx_q <= 1'b0;
      rec_hi_q <= 1'b0;
      scl_lo_q <= 1'b0;
      sda_lo_q <= 1'b0;
    end else if (ce_in) begin
      if (wr_go && hit_tx) begin
        tx_q <= wb_dat_in[7:0];
      end
      if (!busy) begin
        // Software orders start, bytes and stop in sequence
        if (wr_go && hit_cmd && cmd_ok) begin
          op_q <= tw_op_t'(wb_dat_in[2:0]);
          ackbit_q <= wb_dat_in[CMD_ACK_BIT];
          bit_q <= 4'h0;
          ph_q <= 2'h0;
          qcnt_q <= 6'h00;
          sh_q <= tx_q;
          rec_hi_q <= 1'b0;
        end
      end else begin
        scl_lo_q <= !scl_v;
        sda_lo_q <= !sda_v;
        if (!tick) begin
          qcnt_q <= qcnt_q + 6'h01;
        end else begin
          qcnt_q <= 6'h00;
          ph_q <= ph_q + 2'h1;
          if (ph_q == 2'h2) begin
            // Sample while the clock is high
            if ((op_q == OP_WRITE) && last_bit) begin
              ack_rx_q <= !sda_l;
            end
            if ((op_q == OP_READ) && !last_bit) begin
              rx_q <= {rx_q[6:0], sda_l};
            end
            if (op_q == OP_RECOVER) begin
              rec_hi_q <= sda_l;
            end
          end
          if (ph_q == 2'h3) begin
            if ((op_q == OP_START) || (op_q == OP_STOP)) begin
              op_q <= OP_NONE;
            end else if (op_q == OP_RECOVER) begin
              if (rec_hi_q || (bit_q == 4'(RECOVER_MAX - 1))) begin
                op_q <= OP_START;
                bit_q <= 4'h0;
              end else begin
                bit_q <= bit_q + 4'h1;
              end
            end else begin
              sh_q <= {sh_q[6:0], 1'b0};
              if (last_bit) begin
                op_q <= OP_NONE;
              end else begin
                bit_q <= bit_q + 4'h1;
              end
            end
          end
        end
      end
    end
  end

  // Open-drain drive of both lines
  assign bus.ctl_scl_out = 1'b0;
  assign bus.ctl_scl_oe = scl_lo_q;
  assign bus.ctl_sda_out = 1'b0;
  assign bus.ctl_sda_oe = sda_lo_q;
endmodule
`default_nettype wire

// ### verif/tw_chk.sv
// Concurrent checks on the two-wire link and the register port
`timescale 1ns/1ns
`default_nettype none
module tw_chk
  import tw_pkg::*;
#(
  parameter int PROG_CYC_P = PROG_CYC
) (
  // Clock, reset, enable
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // Bus levels and drivers
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_sda_oe,
  input wire logic ctl_sda_oe,
  // Target status
  input wire logic standby_out,
  input wire logic busy_out,
  // Register port handshake
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_ack_out
);
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);

  // Length of the current program cycle, enabled cycles only
  logic [31:0] busy_cnt_q;
  logic [31:0] busy_cnt_d;
  assign busy_cnt_d = busy_out ? (ce_in ? busy_cnt_q + 32'h1 : busy_cnt_q) : 32'h0;
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      busy_cnt_q <= 32'h0;
    end else begin
      busy_cnt_q <= busy_cnt_d;
    end
  end

  // Target drive only moves while the clock line is low
  a_dev_sda_lowclk: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("target data drive changed with clock high");
  a_dev_ack_hold: assert property ($rose(scl) && dev_sda_oe |=> dev_sda_oe [*8])
    else $error("target released data during clock high");
  a_start_by_ctl: assert property ($fell(sda) && scl |-> ctl_sda_oe)
    else $error("start edge not made by controller");
  a_stop_release: assert property ($rose(sda) && scl |-> !dev_sda_oe)
    else $error("target holds data at stop");
  a_busy_quiet: assert property (busy_out |-> !dev_sda_oe)
    else $error("target answered while programming");
  a_busy_limit: assert property (busy_cnt_q <= 32'(PROG_CYC_P))
    else $error("program cycle too long");
  a_busy_standby: assert property ($fell(busy_out) |-> standby_out)
    else $error("no standby after program cycle");
  a_standby_busy: assert property (busy_out |-> !standby_out)
    else $error("standby during program cycle");
  a_idle_quiet: assert property (standby_out |-> !dev_sda_oe)
    else $error("target drives data in standby");
  a_wb_answer: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out && ce_in |=> wb_ack_out)
    else $error("register port answer late");

  // Main scenarios reached
  c_prog: cover property ($rose(busy_out));
  c_ack: cover property ($rose(dev_sda_oe));
  c_start: cover property ($fell(sda) && scl);
  c_stop: cover property ($rose(sda) && scl);
endmodule
`default_nettype wire

// ### verif/two_wire_eeprom_write_port_tb_top.sv
// Self-checking bench: controller and target joined over the two-wire bus
`timescale 1ns/1ns
`default_nettype none
module two_wire_eeprom_write_port_tb_top
  import tw_pkg::*;
;
  localparam int PROG = 2048;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic want = 1'b0;
  logic wp = 1'b0;
  logic [2:0] strap = 3'h0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic standby;
  logic busy;
  logic [63:0] exq[$];
  logic [63:0] e;
  logic [7:0] dv [3];
  logic [12:0] base;
  integer seed = 98;
  int checked = 0;
  int bad_count = 0;
  int n;

  // Clock
  always #10 clk = ~clk;

  tw_bus_if tw_bus_if_inst ();
  tw_ctl tw_ctl_inst (.ref_clk_in(clk), .rst_in(rst), .ce_in(ce), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hf), .wb_dat_in(wdat),
    .wb_dat_out(rdat), .wb_ack_out(ack), .bus(tw_bus_if_inst));
  tw_dev #(.PROG_CYC_P(PROG)) tw_dev_inst (.ref_clk_in(clk), .rst_in(rst), .ce_in(ce),
    .bus(tw_bus_if_inst), .strap_sel_bit2_in(strap[2]), .strap_sel_bit1_in(strap[1]),
    .strap_sel_bit0_in(strap[0]), .write_protect_in(wp), .standby_out(standby),
    .busy_out(busy));
  tw_chk #(.PROG_CYC_P(PROG)) tw_chk_inst (.ref_clk_in(clk), .rst_in(rst), .ce_in(ce),
    .scl(tw_bus_if_inst.scl), .sda(tw_bus_if_inst.sda), .dev_sda_oe(tw_bus_if_inst.dev_sda_oe),
    .ctl_sda_oe(tw_bus_if_inst.ctl_sda_oe), .standby_out(standby), .busy_out(busy),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_ack_out(ack));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // One classic cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic k);
    int c;
    c = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    want <= k;
    do begin
      @(posedge clk);
      c++;
    end while (ack !== 1'b1 && c < 50);
    if (ack !== 1'b1) begin
      bad_count++;
    end
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // Read with a noted expectation
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    exq.push_back({m, x});
    wb(1'b0, a, 32'h0, 1'b1);
  endtask

  // Issue a command and wait until the controller is idle
  task automatic op(input logic [3:0] cmd, input logic [7:0] tx);
    int c;
    c = 0;
    if (cmd[2:0] == OP_WRITE) begin
      wb(1'b1, REG_TX, {24'h0, tx}, 1'b0);
    end
    wb(1'b1, REG_CMD, {28'h0, cmd}, 1'b0);
    do begin
      wb(1'b0, REG_CMD, 32'h0, 1'b0);
      c++;
    end while (rdat[STAT_BUSY] !== 1'b0 && c < 5000);
    if (rdat[STAT_BUSY] !== 1'b0) begin
      bad_count++;
    end
  endtask

  task automatic wbyte(input logic [7:0] b, input logic a);
    op({1'b0, OP_WRITE}, b);
    rd(REG_CMD, 32'h2, {30'h0, a, 1'b0});
  endtask

  task automatic sel_dev(input logic rw, input logic a);
    op({1'b0, OP_START}, 8'h0);
    wbyte({DEV_TYPE, strap, rw}, a);
  endtask

  // Random read, optionally one more byte after a controller ack
  task automatic rdat_chk(input logic [12:0] ad, input logic [7:0] x, input logic sq,
                          input logic [7:0] x2);
    sel_dev(1'b0, 1'b1);
    wbyte({3'h0, ad[12:8]}, 1'b1);
    wbyte(ad[7:0], 1'b1);
    sel_dev(1'b1, 1'b1);
    op({sq, OP_READ}, 8'h0);
    rd(REG_RX, 32'hff, {24'h0, x});
    if (sq) begin
      op({1'b0, OP_READ}, 8'h0);
      rd(REG_RX, 32'hff, {24'h0, x2});
    end
    op({1'b0, OP_STOP}, 8'h0);
  endtask

  // Oldest note compared when a read is answered
  always @(posedge clk) begin
    if (cyc && stb && !we && ack === 1'b1 && want && exq.size() > 0) begin
      e = exq.pop_front();
      check(rdat & e[63:32], e[31:0]);
    end
  end

  // Watchdog
  initial begin
    repeat (90000) @(posedge clk);
    bad_count++;
    conclude();
  end

  initial begin
    strap = 3'($random(seed));
    base = {8'($random(seed)), 5'h00};
    for (int i = 0; i < 3; i++) begin
      dv[i] = 8'($random(seed));
    end
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (10) @(posedge clk);
    // Register reset values, unmapped place, TX read back
    rd(REG_TX, 32'hffffffff, {24'h0, TX_RST});
    rd(REG_RX, 32'hffffffff, {24'h0, RX_RST});
    wb(1'b1, 8'h0c, 32'hff, 1'b0);
    rd(8'h0c, 32'hffffffff, 32'h0);
    wb(1'b1, REG_TX, {24'h0, dv[0]}, 1'b0);
    rd(REG_TX, 32'hff, {24'h0, dv[0]});
    $display("register test done");
    // Three bytes from page offset 30 wrap to offset 0
    sel_dev(1'b0, 1'b1);
    wbyte({3'h0, base[12:8]}, 1'b1);
    wbyte(base[7:0] + 8'd30, 1'b1);
    for (int i = 0; i < 3; i++) begin
      wbyte(dv[i], 1'b1);
    end
    op({1'b0, OP_STOP}, 8'h0);
    check({31'h0, busy}, 32'h1);
    // Enable low freezes the target's program count
    ce <= 1'b0;
    repeat (2100) @(posedge clk);
    check({31'h0, busy}, 32'h1);
    ce <= 1'b1;
    sel_dev(1'b0, 1'b0);
    op({1'b0, OP_STOP}, 8'h0);
    n = 0;
    while (busy === 1'b1 && n < 5000) begin
      @(posedge clk);
      n++;
    end
    if (busy !== 1'b0) begin
      bad_count++;
    end
    @(posedge clk);
    check({31'h0, standby}, 32'h1);
    sel_dev(1'b0, 1'b1);
    op({1'b0, OP_STOP}, 8'h0);
    $display("page write test done");
    // Protected write is acked but never programmed
    wp <= 1'b1;
    sel_dev(1'b0, 1'b1);
    wbyte({3'h0, base[12:8]}, 1'b1);
    wbyte(base[7:0], 1'b1);
    wbyte(~dv[2], 1'b1);
    op({1'b0, OP_STOP}, 8'h0);
    check({31'h0, busy}, 32'h0);
    wp <= 1'b0;
    rdat_chk(base, dv[2], 1'b0, 8'h00);
    rdat_chk(base + 13'd30, dv[0], 1'b1, dv[1]);
    $display("protect and read back test done");
    // Wrong straps, then traffic ignored; wrong type code
    op({1'b0, OP_START}, 8'h0);
    wbyte({DEV_TYPE, strap ^ 3'h1, 1'b0}, 1'b0);
    wbyte(8'h00, 1'b0);
    op({1'b0, OP_STOP}, 8'h0);
    op({1'b0, OP_START}, 8'h0);
    wbyte({DEV_TYPE ^ 4'h1, strap, 1'b0}, 1'b0);
    op({1'b0, OP_STOP}, 8'h0);
    $display("address mismatch test done");
    // Bus recovery sees the data line high
    op({1'b0, OP_RECOVER}, 8'h0);
    rd(REG_CMD, 32'h4, 32'h4);
    op({1'b0, OP_STOP}, 8'h0);
    $display("recovery test done");
    conclude();
  end
endmodule
`default_nettype wire
